// >>> rtl/ssag_guard.sv
/*
 * Security supervisor access guard: detector event log and reaction,
 * security register write window, memory protection, flash execution
 * check, address map check and one-way test-to-normal switch.
 * Assumes detector and test-protocol inputs are asynchronous pins and the
 * processor bus check signals are on ref_clk.
 */
// Our own choices: the address-and-strobe port and the address map.
// Summary of operation
// - every detector event is latched into a readable status register
// - per light, laser, insulation or shield detector, software picks chip reset or fast interrupt reaction
// - frequency, voltage, temperature or glitch events force reset
// - eight detector inputs: freq, volt, temp, light, laser, insulation, shield, glitch
// - no register can disable detection; only the reaction is configurable
// - physical attack detection causes reset or fast interrupt
// - security registers lock unless write-enable set within 128 cycles of reset
// - access to an invalid address raises the fast interrupt
// - access rights from memory access config and regions; violation interrupts
// - eight protection regions, each with its own attributes
// - region violation raises interrupt and sets a monitor flag
// - flash fetches checked against execute rights; invalid fetch interrupts
// - checks depend on privileged or user mode; privileged code configures
// - power-on reset returns every register to its default
// - test to normal switch holds until the next reset
// - traceability area is read-only in normal mode
// - test mode granted only after password accepted
// - normal mode rejects test commands and functional tests
`timescale 1ns/10ps
`default_nettype none
module ssag_guard
	import ssag_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	input wire logic [SSAG_NUM_DET-1:0] det_event,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_fetch,
	input wire logic bus_priv,
	output logic bus_block_ff,
	input wire logic test_pwd_ok,
	input wire logic test_cmd,
	output logic test_cmd_ok_ff,
	output logic test_mode_ff,
	output logic nonmaskable_fast_interrupt_ff,
	output logic chip_reset_ff
);
	logic [SSAG_NUM_DET-1:0] det_s1_ff;
	logic [SSAG_NUM_DET-1:0] det_s2_ff;
	logic [SSAG_NUM_DET-1:0] det_prev_ff;
	logic [1:0] pwd_sync_ff;
	logic [1:0] tcmd_sync_ff;
	logic [SSAG_NUM_DET-1:0] det_status_ff;
	logic [SSAG_NUM_DET-1:0] det_react_ff;
	logic [7:0] mem_access_config_ff;
	logic [7:0] fast_irq_violation_monitor_ff;
	logic [7:0] region_base_ff [SSAG_NUM_REGION];
	logic [7:0] region_limit_ff [SSAG_NUM_REGION];
	logic [7:0] region_attr_ff [SSAG_NUM_REGION];
	logic [7:0] win_cnt_ff;
	logic win_open_ff;
	logic sec_wren_ff;
	logic sec_lock_ff;
	ssag_mode_type mode_ff;
	logic [3:0] rst_cnt_ff;
	logic [SSAG_NUM_DET-1:0] det_rise;
	logic [SSAG_NUM_DET-1:0] fatal_mask;
	logic react_reset;
	logic sec_wr;
	logic sec_reg_sel;
	logic ram_deny;
	logic [2:0] reg_idx;
	logic [7:0] viol_set;
	logic [7:0] nxt_rdata;
	logic region_hit;
	logic region_deny;
	logic invalid_addr;
	logic exec_deny;
	logic trace_deny;
	logic test_rise;

	// pin synchronisers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			det_s1_ff <= '0;
			det_s2_ff <= '0;
			det_prev_ff <= '0;
			pwd_sync_ff <= 2'h0;
			tcmd_sync_ff <= 2'h0;
		end
		else
		begin
			det_s1_ff <= det_event;
			det_s2_ff <= det_s1_ff;
			det_prev_ff <= det_s2_ff;
			pwd_sync_ff <= {pwd_sync_ff[0], test_pwd_ok};
			tcmd_sync_ff <= {tcmd_sync_ff[0], test_cmd};
		end
	end

	assign det_rise = det_s2_ff & ~det_prev_ff;
	assign test_rise = tcmd_sync_ff[1];
	// environmental failures always reset
	assign fatal_mask = SSAG_NUM_DET'((1 << SSAG_DET_FREQ) | (1 << SSAG_DET_VOLT)
		| (1 << SSAG_DET_TEMP) | (1 << SSAG_DET_GLITCH));
	assign react_reset = |(det_s2_ff & (det_react_ff | fatal_mask));

	// security register write window
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			win_cnt_ff <= 8'h00;
			win_open_ff <= 1'b1;
		end
		else if (win_open_ff)
		begin
			win_cnt_ff <= win_cnt_ff + 8'h01;
			if (win_cnt_ff == SSAG_WIN_LAST)
				win_open_ff <= 1'b0;
		end
	end

	assign reg_idx = reg_addr[4:2];
	assign sec_wr = reg_wr && !sec_lock_ff;
	// only security registers count as refused writes once locked
	assign sec_reg_sel = reg_addr == SSAG_OFS_SEC_WREN || reg_addr == SSAG_OFS_DET_REACT
		|| reg_addr == SSAG_OFS_MEM_ACCESS_CFG || reg_addr[7:5] == SSAG_OFS_REGION_BASE[7:5]
		|| reg_addr[7:5] == SSAG_OFS_REGION_LIMIT[7:5] || reg_addr[7:5] == SSAG_OFS_REGION_ATTR[7:5];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec_wren_ff <= 1'b0;
			sec_lock_ff <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == SSAG_OFS_SEC_WREN && win_open_ff && reg_wdata[0])
				sec_wren_ff <= 1'b1;
			if (!win_open_ff && !sec_wren_ff && !(reg_wr && reg_addr == SSAG_OFS_SEC_WREN))
				sec_lock_ff <= 1'b1;
			else if (win_open_ff && win_cnt_ff == SSAG_WIN_LAST && !sec_wren_ff
				&& !(reg_wr && reg_addr == SSAG_OFS_SEC_WREN && reg_wdata[0]))
				sec_lock_ff <= 1'b1;
		end
	end

	// detector status, reaction config
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			det_status_ff <= '0;
		else if (reg_wr && reg_addr == SSAG_OFS_DET_STATUS)
			det_status_ff <= (det_status_ff & ~reg_wdata) | det_rise;
		else
			det_status_ff <= det_status_ff | det_rise;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			det_react_ff <= SSAG_RST_REACT;
			mem_access_config_ff <= SSAG_RST_MAC;
		end
		else if (sec_wr)
		begin
			// only the reaction is writable; detection has no off switch
			if (reg_addr == SSAG_OFS_DET_REACT)
				det_react_ff <= reg_wdata;
			if (reg_addr == SSAG_OFS_MEM_ACCESS_CFG && bus_priv)
				mem_access_config_ff <= reg_wdata;
		end
	end

	// protection regions, privileged configuration only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < SSAG_NUM_REGION; i++)
			begin
				region_base_ff[i] <= 8'h00;
				region_limit_ff[i] <= 8'h00;
				region_attr_ff[i] <= SSAG_RST_ATTR;
			end
		end
		else if (sec_wr && bus_priv)
		begin
			if (reg_addr[7:5] == SSAG_OFS_REGION_BASE[7:5])
				region_base_ff[reg_idx] <= reg_wdata;
			if (reg_addr[7:5] == SSAG_OFS_REGION_LIMIT[7:5])
				region_limit_ff[reg_idx] <= reg_wdata;
			if (reg_addr[7:5] == SSAG_OFS_REGION_ATTR[7:5])
				region_attr_ff[reg_idx] <= reg_wdata;
		end
	end

	// access checks
	always_comb
	begin
		region_hit = 1'b0;
		region_deny = 1'b0;
		for (int i = 0; i < SSAG_NUM_REGION; i++)
		begin
			if (region_attr_ff[i][SSAG_ATTR_EN] && bus_addr[15:8] >= region_base_ff[i]
				&& bus_addr[15:8] <= region_limit_ff[i])
			begin
				region_hit = 1'b1;
				if (!bus_priv && ((bus_write && !region_attr_ff[i][SSAG_ATTR_UW])
					|| (!bus_write && !region_attr_ff[i][SSAG_ATTR_UR])
					|| (bus_fetch && !region_attr_ff[i][SSAG_ATTR_UX])))
					region_deny = 1'b1;
				if (bus_priv && bus_write && !region_attr_ff[i][SSAG_ATTR_PW])
					region_deny = 1'b1;
			end
		end
	end

	assign invalid_addr = bus_addr[31:24] > SSAG_MAP_TRACE
		|| (bus_fetch && (bus_addr[31:24] == SSAG_MAP_SFR || bus_addr[31:24] == SSAG_MAP_TRACE))
		|| (bus_write && bus_addr[31:24] == SSAG_MAP_ROM);
	assign exec_deny = bus_fetch && bus_addr[31:24] == SSAG_MAP_FLASH
		&& !(bus_priv ? mem_access_config_ff[SSAG_MAC_FLASH_PX]
		: mem_access_config_ff[SSAG_MAC_FLASH_UX]);
	assign trace_deny = bus_write && bus_addr[31:24] == SSAG_MAP_TRACE && mode_ff != SSAG_MODE_TEST;
	// user access to ram outside any region
	assign ram_deny = !bus_priv && !region_hit && bus_addr[31:24] == SSAG_MAP_RAM
		&& !mem_access_config_ff[SSAG_MAC_RAM_UACC];

	always_comb
	begin
		viol_set = 8'h00;
		if (bus_valid)
		begin
			viol_set[SSAG_VIOL_INVALID] = invalid_addr;
			viol_set[SSAG_VIOL_REGION] = region_deny || ram_deny;
			viol_set[SSAG_VIOL_EXEC] = exec_deny;
			viol_set[SSAG_VIOL_TRACE] = trace_deny;
		end
		viol_set[SSAG_VIOL_SECWR] = reg_wr && sec_reg_sel && sec_lock_ff;
		viol_set[SSAG_VIOL_TESTCMD] = test_rise && mode_ff != SSAG_MODE_TEST;
		viol_set[SSAG_VIOL_PHYS] = |(det_rise & ~det_react_ff & ~fatal_mask);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fast_irq_violation_monitor_ff <= 8'h00;
		else if (reg_wr && reg_addr == SSAG_OFS_VIOL_MON)
			fast_irq_violation_monitor_ff <= (fast_irq_violation_monitor_ff & ~reg_wdata) | viol_set;
		else
			fast_irq_violation_monitor_ff <= fast_irq_violation_monitor_ff | viol_set;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nonmaskable_fast_interrupt_ff <= 1'b0;
			bus_block_ff <= 1'b0;
		end
		else
		begin
			nonmaskable_fast_interrupt_ff <= |viol_set || |fast_irq_violation_monitor_ff;
			bus_block_ff <= bus_valid && (invalid_addr || region_deny || ram_deny || exec_deny
				|| trace_deny);
		end
	end

	// one-way mode switch
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_ff <= SSAG_MODE_LOCKED;
		else
		begin
			case (mode_ff)
				SSAG_MODE_LOCKED:
					if (pwd_sync_ff[1])
						mode_ff <= SSAG_MODE_TEST;
					else if (reg_wr && reg_addr == SSAG_OFS_MODE && reg_wdata == SSAG_MODE_CODE_NORMAL)
						mode_ff <= SSAG_MODE_NORMAL;
				SSAG_MODE_TEST:
					if (reg_wr && reg_addr == SSAG_OFS_MODE && reg_wdata == SSAG_MODE_CODE_NORMAL)
						mode_ff <= SSAG_MODE_NORMAL;
				SSAG_MODE_NORMAL:
					mode_ff <= SSAG_MODE_NORMAL;
				default:
					mode_ff <= SSAG_MODE_NORMAL;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			test_cmd_ok_ff <= 1'b0;
			test_mode_ff <= 1'b0;
		end
		else
		begin
			test_cmd_ok_ff <= test_rise && mode_ff == SSAG_MODE_TEST;
			test_mode_ff <= mode_ff == SSAG_MODE_TEST;
		end
	end

	// chip reset pulse
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_cnt_ff <= 4'h0;
			chip_reset_ff <= 1'b0;
		end
		else
		begin
			if (react_reset)
				rst_cnt_ff <= SSAG_RST_PULSE;
			else if (rst_cnt_ff != 4'h0)
				rst_cnt_ff <= rst_cnt_ff - 4'h1;
			chip_reset_ff <= react_reset || rst_cnt_ff != 4'h0;
		end
	end

	// register read
	always_comb
	begin
		nxt_rdata = 8'h00;
		case (reg_addr[7:5])
			SSAG_OFS_REGION_BASE[7:5]:
				nxt_rdata = region_base_ff[reg_idx];
			SSAG_OFS_REGION_LIMIT[7:5]:
				nxt_rdata = region_limit_ff[reg_idx];
			SSAG_OFS_REGION_ATTR[7:5]:
				nxt_rdata = region_attr_ff[reg_idx];
			default:
				case (reg_addr)
					SSAG_OFS_DET_STATUS:
						nxt_rdata = det_status_ff;
					SSAG_OFS_DET_REACT:
						nxt_rdata = det_react_ff;
					SSAG_OFS_SEC_WREN:
						nxt_rdata = {6'h00, sec_lock_ff, sec_wren_ff};
					SSAG_OFS_MEM_ACCESS_CFG:
						nxt_rdata = mem_access_config_ff;
					SSAG_OFS_VIOL_MON:
						nxt_rdata = fast_irq_violation_monitor_ff;
					SSAG_OFS_MODE:
						nxt_rdata = {6'h00, mode_ff};
					default:
						nxt_rdata = 8'h00;
				endcase
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_ff <= 8'h00;
		else
			reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
	end
endmodule
`default_nettype wire

// >>> rtl/ssag_pkg.sv
/*
 * Constants for the security supervisor access guard: register map,
 * field positions, reset values and timing counts.
 * Assumes a 32-bit processor address space and 8-bit register data.
 */
package ssag_pkg;
	// register offsets (byte addresses, word aligned)
	localparam logic [7:0] SSAG_OFS_DET_STATUS = 8'h00;
	localparam logic [7:0] SSAG_OFS_DET_REACT = 8'h04;
	localparam logic [7:0] SSAG_OFS_SEC_WREN = 8'h08;
	localparam logic [7:0] SSAG_OFS_MEM_ACCESS_CFG = 8'h0C;
	localparam logic [7:0] SSAG_OFS_VIOL_MON = 8'h10;
	localparam logic [7:0] SSAG_OFS_MODE = 8'h14;
	localparam logic [7:0] SSAG_OFS_REGION_BASE = 8'h40;
	localparam logic [7:0] SSAG_OFS_REGION_LIMIT = 8'h60;
	localparam logic [7:0] SSAG_OFS_REGION_ATTR = 8'h80;
	// detector bit positions
	localparam int SSAG_DET_FREQ = 0;
	localparam int SSAG_DET_VOLT = 1;
	localparam int SSAG_DET_TEMP = 2;
	localparam int SSAG_DET_LIGHT = 3;
	localparam int SSAG_DET_LASER = 4;
	localparam int SSAG_DET_INSUL = 5;
	localparam int SSAG_DET_SHIELD = 6;
	localparam int SSAG_DET_GLITCH = 7;
	localparam int SSAG_NUM_DET = 8;
	localparam int SSAG_NUM_REGION = 8;
	// violation monitor bit positions
	localparam int SSAG_VIOL_INVALID = 0;
	localparam int SSAG_VIOL_REGION = 1;
	localparam int SSAG_VIOL_EXEC = 2;
	localparam int SSAG_VIOL_SECWR = 3;
	localparam int SSAG_VIOL_TRACE = 4;
	localparam int SSAG_VIOL_TESTCMD = 5;
	localparam int SSAG_VIOL_PHYS = 6;
	// region attribute bits: user read, user write, user exec, privileged write
	localparam int SSAG_ATTR_UR = 0;
	localparam int SSAG_ATTR_UW = 1;
	localparam int SSAG_ATTR_UX = 2;
	localparam int SSAG_ATTR_PW = 3;
	localparam int SSAG_ATTR_EN = 7;
	// memory access config bits
	localparam int SSAG_MAC_FLASH_UX = 0;
	localparam int SSAG_MAC_FLASH_PX = 1;
	localparam int SSAG_MAC_RAM_UACC = 2;
	// reset values and normal-mode switch code
	localparam logic [7:0] SSAG_RST_REACT = 8'hFF;
	localparam logic [7:0] SSAG_RST_MAC = 8'h03;
	localparam logic [7:0] SSAG_RST_ATTR = 8'h00;
	localparam logic [7:0] SSAG_MODE_CODE_NORMAL = 8'hA5;
	// address map (upper byte of the address)
	localparam logic [7:0] SSAG_MAP_ROM = 8'h00;
	localparam logic [7:0] SSAG_MAP_FLASH = 8'h01;
	localparam logic [7:0] SSAG_MAP_RAM = 8'h02;
	localparam logic [7:0] SSAG_MAP_SFR = 8'h03;
	localparam logic [7:0] SSAG_MAP_TRACE = 8'h04;
	// write-enable window
	localparam int SSAG_WIN_CYCLES = 128;
	localparam logic [7:0] SSAG_WIN_LAST = 8'(SSAG_WIN_CYCLES - 1);
	// reset pulse length issued on a reset reaction
	localparam logic [3:0] SSAG_RST_PULSE = 4'h8;
	typedef enum logic [1:0]
	{
		SSAG_MODE_LOCKED = 2'b00,
		SSAG_MODE_TEST = 2'b01,
		SSAG_MODE_NORMAL = 2'b10
	} ssag_mode_type;
endpackage

// >>> tb/ssag_guard_assertions.sv
/*
 * port checker for ssag_guard
 * bound to every ssag_guard instance, sees only its ports
 */
`timescale 1ns/10ps
`default_nettype none
module ssag_guard_chk
	import ssag_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic [SSAG_NUM_DET-1:0] det_event,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic bus_write,
	input wire logic test_pwd_ok,
	input wire logic test_cmd_ok_ff,
	input wire logic test_mode_ff,
	input wire logic nonmaskable_fast_interrupt_ff,
	input wire logic chip_reset_ff
);
	wire logic mon_clr;
	assign mon_clr = reg_wr && reg_addr == SSAG_OFS_VIOL_MON;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_bad_map;
		bus_valid && bus_addr[31:24] > SSAG_MAP_TRACE;
	endsequence
	sequence s_trace_wr;
		bus_valid && bus_write && bus_addr[31:24] == SSAG_MAP_TRACE && !test_mode_ff;
	endsequence
	a_bad_addr_irq: assert property (s_bad_map |=> nonmaskable_fast_interrupt_ff)
		else $error("invalid address left no interrupt");
	a_trace_read_only: assert property (s_trace_wr |=> nonmaskable_fast_interrupt_ff)
		else $error("trace write outside test not flagged");
	a_freq_reset: assert property ($rose(det_event[SSAG_DET_FREQ]) |-> ##[1:5] chip_reset_ff)
		else $error("frequency event gave no reset");
	a_reset_hold: assert property ($rose(chip_reset_ff) |-> chip_reset_ff [*8])
		else $error("reset request too short");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
		else $error("read data outside read slot");
	a_irq_held: assert property ($fell(nonmaskable_fast_interrupt_ff) |-> $past(mon_clr) || $past(mon_clr, 2))
		else $error("interrupt dropped without clear");
	a_test_pwd: assert property ($rose(test_mode_ff) |-> $past(test_pwd_ok, 2))
		else $error("test mode without password");
	a_normal_final: assert property ($fell(test_mode_ff) |-> !test_mode_ff [*8])
		else $error("test mode came back");
	a_cmd_in_test: assert property (test_cmd_ok_ff |-> test_mode_ff || $past(test_mode_ff))
		else $error("test command taken outside test");
endmodule
bind ssag_guard ssag_guard_chk u_chk (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata_ff,
	.det_event, .bus_valid, .bus_addr, .bus_write, .test_pwd_ok, .test_cmd_ok_ff, .test_mode_ff,
	.nonmaskable_fast_interrupt_ff, .chip_reset_ff);
`default_nettype wire

// >>> tb/ssag_cpu_model.sv
/*
 * processor core model: one bus access at a time
 * expects ref_clk from the bench
 */
`timescale 1ns/10ps
`default_nettype none
module ssag_cpu_model (
	input wire logic ref_clk,
	output var logic bus_valid,
	output var logic [31:0] bus_addr,
	output var logic bus_write,
	output var logic bus_fetch,
	output var logic bus_priv
);
	initial
	begin
		bus_valid = 1'b0;
		bus_addr = 32'h0;
		bus_write = 1'b0;
		bus_fetch = 1'b0;
		bus_priv = 1'b1;
	end
	task automatic set_priv(input logic p);
		@(posedge ref_clk);
		bus_priv <= p;
	endtask
	task automatic access(input logic [31:0] a, input logic w, f, p);
		@(posedge ref_clk);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_write <= w;
		bus_fetch <= f;
		bus_priv <= p;
		@(posedge ref_clk);
		bus_valid <= 1'b0;
		// idle bus carries no stale address, write or fetch value
		bus_addr <= ~a;
		bus_write <= ~w;
		bus_fetch <= ~f;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * self-checking bench for ssag_guard
 * assumes the checker is bound and the cpu model drives the bus
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, v); end end
module tb_top
	import ssag_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] det_event = 8'h00;
	logic test_pwd_ok = 1'b0;
	logic test_cmd = 1'b0;
	logic [7:0] rdata;
	logic bus_valid, bus_write, bus_fetch, bus_priv, blk, cmd_ok, tmode, irq, crst;
	logic [31:0] bus_addr;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	ssag_cpu_model cpu (.ref_clk(ref_clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_write(bus_write), .bus_fetch(bus_fetch), .bus_priv(bus_priv));
	ssag_guard uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .det_event(det_event),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write), .bus_fetch(bus_fetch),
		.bus_priv(bus_priv), .bus_block_ff(blk), .test_pwd_ok(test_pwd_ok), .test_cmd(test_cmd),
		.test_cmd_ok_ff(cmd_ok), .test_mode_ff(tmode), .nonmaskable_fast_interrupt_ff(irq),
		.chip_reset_ff(crst));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg", e, rdata)
	endtask
	task automatic acc(input logic [31:0] a, input logic w, f, p, input logic [7:0] e);
		cpu.access(a, w, f, p);
		#1;
		`CHK("blk", (e != 8'h00), blk)
		repeat (2) @(posedge ref_clk);
		rc(SSAG_OFS_VIOL_MON, e);
		`CHK("irq", (e != 8'h00), irq)
		wr(SSAG_OFS_VIOL_MON, 8'hFF);
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic pin_cmd(input logic e);
		@(posedge ref_clk);
		test_cmd <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		`CHK("cmd_ok", e, cmd_ok)
		@(posedge ref_clk);
		test_cmd <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_detect;
		logic [7:0] st;
		st = 8'h00;
		wr(SSAG_OFS_DET_REACT, 8'h00);
		for (int i = 0; i < SSAG_NUM_DET; i++)
		begin
			@(posedge ref_clk);
			det_event[i] <= 1'b1;
			st[i] = 1'b1;
			repeat (6) @(posedge ref_clk);
			#1;
			`CHK("reset", (i < 3 || i == 7), crst)
			@(posedge ref_clk);
			det_event[i] <= 1'b0;
			repeat (12) @(posedge ref_clk);
			rc(SSAG_OFS_DET_STATUS, st);
		end
		rc(SSAG_OFS_VIOL_MON, 8'h40);
		`CHK("irq", 1'b1, irq)
		wr(SSAG_OFS_DET_STATUS, 8'hFF);
		wr(SSAG_OFS_VIOL_MON, 8'hFF);
		rc(SSAG_OFS_DET_STATUS, 8'h00);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_access;
		acc(32'h0500_0000, 1'b0, 1'b0, 1'b0, 8'h01);
		cpu.set_priv(1'b1);
		wr(SSAG_OFS_MEM_ACCESS_CFG, 8'h02);
		wr(SSAG_OFS_REGION_BASE + 8'h1C, 8'h10);
		wr(SSAG_OFS_REGION_LIMIT + 8'h1C, 8'h1F);
		wr(SSAG_OFS_REGION_ATTR + 8'h1C, 8'h81);
		cpu.set_priv(1'b0);
		wr(SSAG_OFS_MEM_ACCESS_CFG, 8'h07);
		rc(SSAG_OFS_MEM_ACCESS_CFG, 8'h02);
		acc(32'h0100_0000, 1'b0, 1'b1, 1'b0, 8'h04);
		acc(32'h0100_0000, 1'b0, 1'b1, 1'b1, 8'h00);
		acc(32'h0200_1500, 1'b1, 1'b0, 1'b0, 8'h02);
		acc(32'h0200_1500, 1'b0, 1'b0, 1'b0, 8'h00);
	endtask
	task automatic t_mode;
		pin_cmd(1'b0);
		wr(SSAG_OFS_VIOL_MON, 8'hFF);
		test_pwd_ok <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("test_mode", 1'b1, tmode)
		pin_cmd(1'b1);
		acc(32'h0400_0010, 1'b1, 1'b0, 1'b1, 8'h00);
		wr(SSAG_OFS_MODE, SSAG_MODE_CODE_NORMAL);
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("test_mode", 1'b0, tmode)
		pin_cmd(1'b0);
		rc(SSAG_OFS_VIOL_MON, 8'h20);
		wr(SSAG_OFS_VIOL_MON, 8'hFF);
		acc(32'h0400_0010, 1'b1, 1'b0, 1'b1, 8'h10);
	endtask
	task automatic t_lock;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (130) @(posedge ref_clk);
		rc(SSAG_OFS_SEC_WREN, 8'h02);
		wr(SSAG_OFS_SEC_WREN, 8'h01);
		wr(SSAG_OFS_DET_REACT, 8'h00);
		rc(SSAG_OFS_DET_REACT, SSAG_RST_REACT);
		rc(SSAG_OFS_VIOL_MON, 8'h08);
		rc(SSAG_OFS_SEC_WREN, 8'h02);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_count++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(SSAG_OFS_SEC_WREN, 8'h01);
		rc(SSAG_OFS_SEC_WREN, 8'h01);
		rc(SSAG_OFS_DET_REACT, SSAG_RST_REACT);
		rc(SSAG_OFS_MEM_ACCESS_CFG, SSAG_RST_MAC);
		rc(SSAG_OFS_REGION_ATTR, SSAG_RST_ATTR);
		rc(SSAG_OFS_VIOL_MON, 8'h00);
		rc(8'h3C, 8'h00);
		t_detect;
		t_access;
		t_mode;
		t_lock;
		report_and_stop;
	end
endmodule
`default_nettype wire
